// [bench/tb_adc_conversion_sequencer.sv]
// Self-checking testbench for the converter sequencer, driven through its Avalon-MM registers.
`timescale 1ns/1ns
module tb_adc_conversion_sequencer;
	import adc_seq_pkg::*;
	logic i_clock, i_reset, i_clock_enable, i_avs_read, i_avs_write, i_sleep, i_comparator, i_rc_clock;
	logic [4:0] i_avs_address;
	logic [31:0] i_avs_writedata, o_avs_readdata;
	logic o_avs_waitrequest, o_analog_on, o_hold_connected, o_irq_request, o_wake, o_isr_request;
	logic [4:0] o_channel_select;
	logic [9:0] o_sar_trial, target;
	logic [31:0] seed, rd;
	int n_mismatch, checks, cyc, rc_cnt, exp_result;
	// The bench clock is not the 8 MHz part clock, so the divide-by-8 bit period limit does not bind here.
	logic [2:0] sels [6] = '{3'h1, 3'h5, 3'h2, 3'h6, 3'h3, 3'h7};
	int divs [6] = '{8, 16, 32, 64, 0, 0};
	logic [4:0] offs [8] = '{5'h00, 5'h04, 5'h08, 5'h0C, 5'h10, 5'h14, 5'h18, 5'h1C};

	adc_conversion_sequencer dut_u (.i_clock(i_clock), .i_reset(i_reset), .i_clock_enable(i_clock_enable),
		.i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
		.i_avs_writedata(i_avs_writedata), .i_sleep(i_sleep), .i_comparator(i_comparator),
		.i_rc_clock(i_rc_clock), .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
		.o_analog_on(o_analog_on), .o_hold_connected(o_hold_connected), .o_channel_select(o_channel_select),
		.o_sar_trial(o_sar_trial), .o_irq_request(o_irq_request), .o_wake(o_wake),
		.o_isr_request(o_isr_request));

	// Free-running 125 MHz system clock.
	initial begin
		i_clock = 1'b0;
		forever #4 i_clock = ~i_clock;
	end

	// Pseudo-random source for targets and channels.
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// The comparator stands in for the analog input: it keeps a trial bit while the trial is not above the target.
	// The internal RC clock runs free with a 24-cycle period, slow enough for the two-flop synchroniser.
	always @(posedge i_clock) begin
		cyc <= cyc + 1;
		i_comparator <= (o_sar_trial <= target);
		rc_cnt <= (rc_cnt == 11) ? 0 : rc_cnt + 1;
		if (rc_cnt == 11) begin
			i_rc_clock <= ~i_rc_clock;
		end
		if (cyc == 60000) begin
			n_mismatch++;
			final_report();
		end
	end

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic final_report();
		if (n_mismatch == 0 && checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// Bus cycles hold the request until waitrequest is seen low at a rising edge, then release it.
	task automatic bus_wr(input logic [4:0] a, input logic [31:0] d);
		i_avs_address <= a;
		i_avs_writedata <= d;
		i_avs_write <= 1'b1;
		@(posedge i_clock);
		while (o_avs_waitrequest !== 1'b0) @(posedge i_clock);
		i_avs_write <= 1'b0;
		@(posedge i_clock);
	endtask

	task automatic bus_rd(input logic [4:0] a, output logic [31:0] d);
		i_avs_address <= a;
		i_avs_read <= 1'b1;
		@(posedge i_clock);
		while (o_avs_waitrequest !== 1'b0) @(posedge i_clock);
		d = o_avs_readdata;
		i_avs_read <= 1'b0;
		@(posedge i_clock);
	endtask

	task automatic start_conv(input logic [2:0] sel, input logic [4:0] ch);
		seed = lfsr(seed);
		target <= seed[9:0];
		bus_wr(OFF_CONV_CTRL_SECOND, {25'h0, sel, 4'h0});
		bus_wr(OFF_CONV_CTRL_FIRST, {25'h0, ch, 2'b11});
	endtask

	// Checks the result pair against the model; the model moves only on a completed conversion or a reset.
	task automatic check_result();
		logic [31:0] v;
		bus_rd(OFF_RESULT_HIGH, v);
		check("result_high", v, {24'h0, 8'(exp_result >> 8)});
		bus_rd(OFF_RESULT_LOW, v);
		check("result_low", v, {24'h0, 8'(exp_result)});
	endtask

	// One full conversion, polling the start bit; with a divider code the elapsed time is bounded by the bit period count.
	task automatic run_conv(input logic [2:0] sel, input int div, input logic [4:0] ch);
		int t0;
		int n;
		start_conv(sel, ch);
		// The registered copies move one edge after the write lands, so look an edge later.
		@(posedge i_clock);
		check("analog_on", {31'h0, o_analog_on}, 32'h1);
		check("channel_out", {27'h0, o_channel_select}, {27'h0, ch});
		t0 = cyc;
		n = 0;
		rd = 32'h2;
		while (rd[BIT_GO] !== 1'b0 && n < 4000) begin
			bus_rd(OFF_CONV_CTRL_FIRST, rd);
			if (n == 0) check("go_busy", rd, {25'h0, ch, 2'b11});
			n++;
		end
		if (div > 0) begin
			check("conv_time", {31'h0, (cyc - t0) >= 10 * div && (cyc - t0) <= 11 * div + 12}, 32'h1);
		end
		exp_result = int'(target);
		check_result();
		bus_rd(OFF_PERIPH_FLAG_REG, rd);
		check("done_flag", rd, 32'h1);
	endtask

	task automatic clear_flag();
		bus_wr(OFF_PERIPH_FLAG_REG, 32'h0);
		repeat (2) @(posedge i_clock);
	endtask

	// Main sequence.
	initial begin
		{i_avs_read, i_avs_write, i_sleep, i_comparator, i_rc_clock, i_avs_address} = '0;
		i_avs_writedata = '0;
		i_clock_enable = 1'b1;
		i_reset = 1'b1;
		target = '0;
		seed = 32'h331B;
		{n_mismatch, checks, cyc, rc_cnt, exp_result} = '0;
		repeat (3) @(posedge i_clock);
		i_reset <= 1'b0;
		@(posedge i_clock);
		check("waitreq_idle", {31'h0, o_avs_waitrequest}, 32'h1);
		// Reset values and the unmapped place, which also ignores a write.
		bus_wr(5'h1C, 32'hFFFF_FFFF);
		foreach (offs[i]) begin
			bus_rd(offs[i], rd);
			check("reset_value", rd, 32'h0);
		end
		bus_wr(OFF_IRQ_CTRL_REG, 32'hC0);
		bus_rd(OFF_IRQ_CTRL_REG, rd);
		check("irq_ctrl_rw", rd, 32'hC0);
		bus_wr(OFF_IRQ_CTRL_REG, 32'h0);
		// Every divider and RC code, with the interrupt enable off; RC conversions run asleep only.
		foreach (sels[i]) begin
			seed = lfsr(seed);
			i_sleep <= (divs[i] == 0);
			run_conv(sels[i], divs[i], seed[14:10]);
			i_sleep <= 1'b0;
			check("irq_off", {31'h0, o_irq_request}, 32'h0);
			clear_flag();
			bus_rd(OFF_PERIPH_FLAG_REG, rd);
			check("flag_cleared", rd, 32'h0);
		end
		// Interrupt request follows flag and enable.
		bus_wr(OFF_PERIPH_ENABLE_REG, 32'h1);
		run_conv(SEL_DIV16, 16, 5'h1F);
		check("irq_on", {31'h0, o_irq_request}, 32'h1);
		clear_flag();
		check("irq_drop", {31'h0, o_irq_request}, 32'h0);
		// Oscillator-derived bit clock halts in sleep and resumes after.
		i_sleep <= 1'b1;
		start_conv(SEL_DIV8, 5'h02);
		repeat (400) @(posedge i_clock);
		bus_rd(OFF_CONV_CTRL_FIRST, rd);
		check("sleep_hold", {31'h0, rd[BIT_GO]}, 32'h1);
		i_sleep <= 1'b0;
		repeat (200) @(posedge i_clock);
		bus_rd(OFF_CONV_CTRL_FIRST, rd);
		check("sleep_resume", {31'h0, rd[BIT_GO]}, 32'h0);
		exp_result = int'(target);
		check_result();
		clear_flag();
		// Code 100 gives no bit clock, so a conversion stalls until a real divider is chosen.
		start_conv(3'h4, 5'h03);
		repeat (200) @(posedge i_clock);
		bus_rd(OFF_CONV_CTRL_FIRST, rd);
		check("stall", {31'h0, rd[BIT_GO]}, 32'h1);
		bus_wr(OFF_CONV_CTRL_SECOND, {25'h0, SEL_DIV16, 4'h0});
		repeat (250) @(posedge i_clock);
		exp_result = int'(target);
		check_result();
		clear_flag();
		// RC clock keeps converting in sleep; the interrupt wakes, the service routine waits for wake.
		bus_wr(OFF_IRQ_CTRL_REG, 32'hC0);
		i_sleep <= 1'b1;
		run_conv(3'h7, 0, 5'h0A);
		repeat (3) @(posedge i_clock);
		check("wake", {31'h0, o_wake}, 32'h1);
		check("isr_in_sleep", {31'h0, o_isr_request}, 32'h0);
		i_sleep <= 1'b0;
		repeat (3) @(posedge i_clock);
		check("isr_awake", {31'h0, o_isr_request}, 32'h1);
		clear_flag();
		// Abort mid-conversion; a start inside the two-period wait is ignored, a later one runs.
		start_conv(SEL_DIV32, 5'h05);
		repeat (100) @(posedge i_clock);
		bus_wr(OFF_CONV_CTRL_FIRST, {25'h0, 5'h05, 2'b01});
		bus_wr(OFF_CONV_CTRL_FIRST, {25'h0, 5'h05, 2'b11});
		bus_rd(OFF_CONV_CTRL_FIRST, rd);
		check("abort_wait", {31'h0, rd[BIT_GO]}, 32'h0);
		check_result();
		bus_rd(OFF_PERIPH_FLAG_REG, rd);
		check("abort_flag", rd, 32'h0);
		repeat (80) @(posedge i_clock);
		check("acquire", {31'h0, o_hold_connected}, 32'h1);
		run_conv(SEL_DIV32, 32, 5'h05);
		// Reset in mid-conversion drops everything.
		start_conv(SEL_DIV64, 5'h11);
		repeat (100) @(posedge i_clock);
		i_reset <= 1'b1;
		repeat (2) @(posedge i_clock);
		i_reset <= 1'b0;
		@(posedge i_clock);
		exp_result = 0;
		bus_rd(OFF_CONV_CTRL_FIRST, rd);
		check("reset_ctrl", rd, 32'h0);
		bus_rd(OFF_CONV_CTRL_SECOND, rd);
		check("reset_sel", rd, 32'h0);
		check_result();
		check("reset_off", {31'h0, o_analog_on}, 32'h0);
		final_report();
	end
endmodule

// [rtl/adc_conversion_sequencer.sv]
// Successive-approximation converter sequencer with Avalon-MM register access.
// Operation
// - Bit clock from select: 001 /8, 101 /16, 010 /32, 110 /64, x11 RC clock.
// - Completion flag sets at every conversion end regardless of interrupt enable.
// - Interrupt request raised while completion flag and its enable are both set.
// - Conversions continue in sleep only with RC clock selected.
// - A converter interrupt during sleep wakes the device.
// - After wake, service routine entered only with global and peripheral enables set.
// - Ten-bit result presented right-justified across high and low registers.
// - Writing one to start bit begins a conversion; bit reads one while busy.
// - On completion: start bit clears, flag sets, result pair loads.
// - Clearing start bit mid-conversion aborts and keeps the previous result.
// - After abort, wait two bit periods before another acquisition.
// - After that wait, acquisition restarts on the selected channel automatically.
// - Device reset returns control bits to reset values and drops any conversion.
// - A full conversion takes exactly eleven bit periods.
// - Five-bit channel select chooses the source for the sample-and-hold.
// - With converter enable zero the converter is off and draws no current.
`timescale 1ns/1ns
module adc_conversion_sequencer
	import adc_seq_pkg::*;
(
	input wire logic i_clock,
	input wire logic i_reset,
	input wire logic i_clock_enable,
	input wire logic [4:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic i_sleep,
	input wire logic i_comparator,
	input wire logic i_rc_clock,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	output logic o_analog_on,
	output logic o_hold_connected,
	output logic [4:0] o_channel_select,
	output logic [9:0] o_sar_trial,
	output logic o_irq_request,
	output logic o_wake,
	output logic o_isr_request
);
	seq_state_t state_r;
	seq_state_t state_nxt;
	logic conv_enable_r;
	logic go_r;
	logic go_nxt;
	logic [4:0] channel_r;
	logic [2:0] clock_select_r;
	logic [9:0] result_r;
	logic [9:0] approx_r;
	logic [9:0] approx_nxt;
	logic [3:0] bit_idx_r;
	logic [1:0] abort_cnt_r;
	logic conv_done_flag_r;
	logic conv_irq_enable_r;
	logic global_irq_enable_r;
	logic periph_irq_enable_r;
	logic cmp_meta_r;
	logic cmp_sync_r;
	logic rc_meta_r;
	logic rc_sync_r;
	logic raw_tick;
	logic tick;
	logic rc_selected;
	logic access;
	logic take;
	logic wr_take;
	logic wr_ctrl_first;
	logic busy;
	logic start;
	logic abort;
	logic done;
	logic irq_level;
	logic [31:0] rd_mux;
	logic [1:0] result_top;

	// Single-bit mask for a bit index of the approximation register.
	function automatic logic [9:0] bit_mask(input logic [3:0] idx);
		bit_mask = 10'h001 << idx;
	endfunction

	// Pin inputs pass two flip-flops; only the second stage is read by logic.
	always_ff @(posedge i_clock or posedge i_reset) begin
		if (i_reset) begin
			cmp_meta_r <= 1'b0;
			cmp_sync_r <= 1'b0;
			rc_meta_r <= 1'b0;
			rc_sync_r <= 1'b0;
		end else if (i_clock_enable) begin
			cmp_meta_r <= i_comparator;
			cmp_sync_r <= cmp_meta_r;
			rc_meta_r <= i_rc_clock;
			rc_sync_r <= rc_meta_r;
		end
	end

	// Bit-period tick source.
	conv_clock_divider u_divider (
		.i_clock(i_clock),
		.i_reset(i_reset),
		.i_clock_enable(i_clock_enable),
		.i_conv_clock_select(clock_select_r),
		.i_rc_level(rc_sync_r),
		.o_tick(raw_tick)
	);

	// Oscillator-derived clocks stop in sleep, so only the RC clock keeps a conversion going.
	assign rc_selected = (clock_select_r[1:0] == SEL_RC_LOW);
	assign tick = raw_tick && (!i_sleep || rc_selected);

	// Bus decode: each request waits one cycle, then completes with waitrequest low.
	assign access = i_avs_read || i_avs_write;
	assign take = access && !o_avs_waitrequest;
	assign wr_take = take && i_avs_write;
	assign wr_ctrl_first = wr_take && (i_avs_address == OFF_CONV_CTRL_FIRST);
	assign busy = (state_r == ST_SAMPLE) || (state_r == ST_CONVERT);
	// A start is only accepted when the same write sets the enable bit and the sequencer is fully idle.
	assign start = wr_ctrl_first && i_avs_writedata[BIT_GO] && (state_r == ST_IDLE)
		&& i_avs_writedata[BIT_CONV_ENABLE];
	// Writing the enable low is a switch-off, not an abort; the forced return to idle handles it.
	assign abort = wr_ctrl_first && !i_avs_writedata[BIT_GO] && i_avs_writedata[BIT_CONV_ENABLE] && busy;
	// A clear of the start bit in the final period wins, so a cut conversion never loads a result.
	assign done = (state_r == ST_CONVERT) && tick && (bit_idx_r == 4'h0)
		&& !(wr_ctrl_first && !i_avs_writedata[BIT_GO]);

	// Read multiplexer; unmapped addresses and unused bits read zero.
	always_comb begin
		rd_mux = 32'h0000_0000;
		case (i_avs_address)
			OFF_CONV_CTRL_FIRST: rd_mux = {25'h0, channel_r, go_r, conv_enable_r};
			OFF_CONV_CTRL_SECOND: rd_mux = {25'h0, clock_select_r, 4'h0};
			OFF_RESULT_HIGH: rd_mux = {30'h0, result_r[9:8]};
			OFF_RESULT_LOW: rd_mux = {24'h0, result_r[7:0]};
			OFF_PERIPH_FLAG_REG: rd_mux = {31'h0, conv_done_flag_r};
			OFF_PERIPH_ENABLE_REG: rd_mux = {31'h0, conv_irq_enable_r};
			OFF_IRQ_CTRL_REG: rd_mux = {24'h0, global_irq_enable_r, periph_irq_enable_r, 6'h00};
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	// Bus answer registers.
	always_ff @(posedge i_clock or posedge i_reset) begin
		if (i_reset) begin
			o_avs_waitrequest <= 1'b1;
			o_avs_readdata <= 32'h0000_0000;
		end else if (i_clock_enable) begin
			o_avs_waitrequest <= !(access && o_avs_waitrequest);
			if (access && o_avs_waitrequest) begin
				o_avs_readdata <= rd_mux;
			end
		end
	end

	// Software-owned configuration bits; reset puts them all back to off.
	always_ff @(posedge i_clock or posedge i_reset) begin
		if (i_reset) begin
			conv_enable_r <= 1'b0;
			channel_r <= RST_CHANNEL;
			clock_select_r <= RST_CLOCK_SELECT;
			conv_irq_enable_r <= 1'b0;
			global_irq_enable_r <= 1'b0;
			periph_irq_enable_r <= 1'b0;
		end else if (i_clock_enable && wr_take) begin
			if (i_avs_address == OFF_CONV_CTRL_FIRST) begin
				conv_enable_r <= i_avs_writedata[BIT_CONV_ENABLE];
				channel_r <= i_avs_writedata[POS_CHANNEL +: 5];
			end
			if (i_avs_address == OFF_CONV_CTRL_SECOND) begin
				clock_select_r <= i_avs_writedata[POS_CLOCK_SELECT +: 3];
			end
			if (i_avs_address == OFF_PERIPH_ENABLE_REG) begin
				conv_irq_enable_r <= i_avs_writedata[BIT_IRQ_ENABLE];
			end
			if (i_avs_address == OFF_IRQ_CTRL_REG) begin
				global_irq_enable_r <= i_avs_writedata[BIT_GLOBAL_IRQ_ENABLE];
				periph_irq_enable_r <= i_avs_writedata[BIT_PERIPH_IRQ_ENABLE];
			end
		end
	end

	// Sequencer next state; turning the converter off drops any conversion at once.
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE: if (start) state_nxt = ST_SAMPLE;
			ST_SAMPLE: begin
				if (abort) state_nxt = ST_ABORT;
				else if (tick) state_nxt = ST_CONVERT;
			end
			ST_CONVERT: begin
				if (abort) state_nxt = ST_ABORT;
				else if (done) state_nxt = ST_IDLE;
			end
			ST_ABORT: if (tick && abort_cnt_r == ABORT_PERIODS - 2'h1) state_nxt = ST_IDLE;
			default: state_nxt = ST_IDLE;
		endcase
		if (wr_ctrl_first && !i_avs_writedata[BIT_CONV_ENABLE]) begin
			state_nxt = ST_IDLE;
		end
	end

	// Start bit: set by software, cleared by completion, abort or converter off.
	assign go_nxt = (state_nxt == ST_SAMPLE || state_nxt == ST_CONVERT) && !done;

	// Trial word: top bit set at the start of resolving, then one bit decided per period.
	assign approx_nxt = (state_r == ST_SAMPLE) ? bit_mask(MSB_INDEX)
		: (cmp_sync_r ? approx_r : approx_r & ~bit_mask(bit_idx_r))
		| ((bit_idx_r != 4'h0) ? bit_mask(bit_idx_r - 4'h1) : 10'h000);

	// Sequencer registers.
	always_ff @(posedge i_clock or posedge i_reset) begin
		if (i_reset) begin
			state_r <= ST_IDLE;
			go_r <= 1'b0;
			approx_r <= 10'h000;
			bit_idx_r <= MSB_INDEX;
			abort_cnt_r <= 2'h0;
		end else if (i_clock_enable) begin
			state_r <= state_nxt;
			go_r <= go_nxt;
			if (tick && busy) begin
				approx_r <= approx_nxt;
				bit_idx_r <= (state_r == ST_SAMPLE) ? MSB_INDEX : bit_idx_r - 4'h1;
			end
			if (state_r != ST_ABORT) begin
				abort_cnt_r <= 2'h0;
			end else if (tick) begin
				abort_cnt_r <= abort_cnt_r + 2'h1;
			end
		end
	end

	// Result and completion flag; the result moves only on a finished conversion.
	always_ff @(posedge i_clock or posedge i_reset) begin
		if (i_reset) begin
			result_r <= RST_RESULT;
			conv_done_flag_r <= 1'b0;
		end else if (i_clock_enable) begin
			if (done) begin
				result_r <= cmp_sync_r ? approx_r : approx_r & ~bit_mask(4'h0);
			end
			// The hardware set wins over a software clear in the same cycle.
			if (done) begin
				conv_done_flag_r <= 1'b1;
			end else if (wr_take && i_avs_address == OFF_PERIPH_FLAG_REG) begin
				conv_done_flag_r <= i_avs_writedata[BIT_DONE_FLAG];
			end
		end
	end

	// Interrupt, wake and service-routine requests to the core.
	assign irq_level = conv_done_flag_r && conv_irq_enable_r;
	always_ff @(posedge i_clock or posedge i_reset) begin
		if (i_reset) begin
			o_irq_request <= 1'b0;
			o_wake <= 1'b0;
			o_isr_request <= 1'b0;
		end else if (i_clock_enable) begin
			o_irq_request <= irq_level;
			o_wake <= irq_level && i_sleep;
			// Held off while asleep so the core runs the instruction after sleep first.
			o_isr_request <= irq_level && !i_sleep && global_irq_enable_r && periph_irq_enable_r;
		end
	end

	// Analog-side controls; the hold stage tracks the channel while the converter is on and idle or sampling.
	always_ff @(posedge i_clock or posedge i_reset) begin
		if (i_reset) begin
			o_analog_on <= 1'b0;
			o_hold_connected <= 1'b0;
			o_channel_select <= RST_CHANNEL;
			o_sar_trial <= 10'h000;
		end else if (i_clock_enable) begin
			o_analog_on <= conv_enable_r;
			o_hold_connected <= conv_enable_r && (state_nxt == ST_IDLE || state_nxt == ST_SAMPLE);
			o_channel_select <= channel_r;
			o_sar_trial <= approx_r;
		end
	end

	// Helper count of bit periods since the start, read only by an assertion.
	logic [3:0] conv_ticks_r;
	always_ff @(posedge i_clock or posedge i_reset) begin
		if (i_reset) begin
			conv_ticks_r <= 4'h0;
		end else if (i_clock_enable) begin
			conv_ticks_r <= start ? 4'h0 : (busy && tick) ? conv_ticks_r + 4'h1 : conv_ticks_r;
		end
	end

	// Top result bits as a named signal, so that the read check can look one edge back.
	assign result_top = result_r[9:8];

	AST_ELEVEN_PERIODS: assert property (@(posedge i_clock) disable iff (i_reset)
		(i_clock_enable && done) |-> conv_ticks_r == CONV_PERIODS - 4'h1)
		else $error("Conversion did not take eleven bit periods.");
	AST_FLAG_ON_DONE: assert property (@(posedge i_clock) disable iff (i_reset)
		(i_clock_enable && done) |=> conv_done_flag_r && !go_r && state_r == ST_IDLE)
		else $error("Completion did not set flag and clear start bit.");
	AST_ABORT_KEEPS_RESULT: assert property (@(posedge i_clock) disable iff (i_reset)
		(i_clock_enable && abort) |=> (state_r == ST_ABORT && !go_r && $stable(result_r)))
		else $error("Abort changed the result or did not stop.");
	AST_ABORT_WAIT: assert property (@(posedge i_clock) disable iff (i_reset)
		(state_r == ST_IDLE && $past(state_r) == ST_ABORT && !$past(wr_ctrl_first))
		|-> $past(abort_cnt_r) == ABORT_PERIODS - 2'h1)
		else $error("Post-abort wait was not two bit periods.");
	AST_IRQ_REQUEST: assert property (@(posedge i_clock) disable iff (i_reset)
		i_clock_enable |=> o_irq_request == $past(irq_level))
		else $error("Interrupt request does not follow flag and enable.");
	AST_SLEEP_STOPS: assert property (@(posedge i_clock) disable iff (i_reset)
		(i_clock_enable && i_sleep && !rc_selected) |=> $stable(approx_r) && $stable(bit_idx_r))
		else $error("Oscillator clock ticked during sleep.");
	AST_WAKE: assert property (@(posedge i_clock) disable iff (i_reset)
		(i_clock_enable && irq_level && i_sleep) |=> o_wake && !o_isr_request)
		else $error("Interrupt in sleep did not wake or entered service early.");
	AST_DISABLED_IDLE: assert property (@(posedge i_clock) disable iff (i_reset)
		!conv_enable_r |-> (state_r == ST_IDLE && !go_r))
		else $error("Converter busy while disabled.");
	AST_HIGH_UPPER_ZERO: assert property (@(posedge i_clock) disable iff (i_reset)
		(i_clock_enable && access && o_avs_waitrequest && i_avs_address == OFF_RESULT_HIGH)
		|=> o_avs_readdata[31:2] == 30'h0 && o_avs_readdata[1:0] == $past(result_top))
		else $error("High result register read wrong bits.");
	AST_RESULT_ONLY_ON_DONE: assert property (@(posedge i_clock) disable iff (i_reset)
		(i_clock_enable && !done) |=> $stable(result_r))
		else $error("Result changed without a completed conversion.");
	AST_START_BUSY: assert property (@(posedge i_clock) disable iff (i_reset)
		(i_clock_enable && start) |=> go_r && state_r == ST_SAMPLE)
		else $error("Start did not enter sampling with the start bit set.");
	AST_FIRST_TRIAL: assert property (@(posedge i_clock) disable iff (i_reset)
		(i_clock_enable && state_r == ST_SAMPLE && tick) |=> approx_r == 10'h200 && bit_idx_r == 4'h9)
		else $error("Resolving did not begin at the top bit.");
	AST_ISR_GATED: assert property (@(posedge i_clock) disable iff (i_reset)
		(i_clock_enable && !(global_irq_enable_r && periph_irq_enable_r)) |=> !o_isr_request)
		else $error("Service request raised without both enables.");
	AST_FLAG_STICKY: assert property (@(posedge i_clock) disable iff (i_reset)
		(i_clock_enable && conv_done_flag_r && !(wr_take && i_avs_address == OFF_PERIPH_FLAG_REG))
		|=> conv_done_flag_r)
		else $error("Completion flag cleared without a software write.");
	AST_ACQUIRE_AFTER_ABORT: assert property (@(posedge i_clock) disable iff (i_reset)
		(i_clock_enable && state_r == ST_ABORT && state_nxt == ST_IDLE && conv_enable_r) |=> o_hold_connected)
		else $error("Acquisition did not restart after the abort wait.");
	AST_ANALOG_FOLLOWS: assert property (@(posedge i_clock) disable iff (i_reset)
		i_clock_enable |=> o_analog_on == $past(conv_enable_r))
		else $error("Analog power does not follow the converter enable.");
endmodule

// [rtl/adc_seq_pkg.sv]
// Package with register map, field positions, reset values and timing counts of the converter sequencer.
package adc_seq_pkg;
	// Register byte offsets on the Avalon-MM slave.
	localparam logic [4:0] OFF_CONV_CTRL_FIRST = 5'h00;
	localparam logic [4:0] OFF_CONV_CTRL_SECOND = 5'h04;
	localparam logic [4:0] OFF_RESULT_HIGH = 5'h08;
	localparam logic [4:0] OFF_RESULT_LOW = 5'h0C;
	localparam logic [4:0] OFF_PERIPH_FLAG_REG = 5'h10;
	localparam logic [4:0] OFF_PERIPH_ENABLE_REG = 5'h14;
	localparam logic [4:0] OFF_IRQ_CTRL_REG = 5'h18;
	// Field positions.
	localparam int BIT_CONV_ENABLE = 0;
	localparam int BIT_GO = 1;
	localparam int POS_CHANNEL = 2;
	localparam int POS_CLOCK_SELECT = 4;
	localparam int BIT_DONE_FLAG = 0;
	localparam int BIT_IRQ_ENABLE = 0;
	localparam int BIT_PERIPH_IRQ_ENABLE = 6;
	localparam int BIT_GLOBAL_IRQ_ENABLE = 7;
	// Reset values.
	localparam logic [4:0] RST_CHANNEL = 5'h00;
	localparam logic [2:0] RST_CLOCK_SELECT = 3'h0;
	localparam logic [9:0] RST_RESULT = 10'h000;
	// Divider selection codes.
	localparam logic [2:0] SEL_DIV8 = 3'h1;
	localparam logic [2:0] SEL_DIV16 = 3'h5;
	localparam logic [2:0] SEL_DIV32 = 3'h2;
	localparam logic [2:0] SEL_DIV64 = 3'h6;
	localparam logic [1:0] SEL_RC_LOW = 2'h3;
	// Oscillator cycles per conversion bit period for each divider setting.
	localparam logic [6:0] DIV8_CYCLES = 7'h08;
	localparam logic [6:0] DIV16_CYCLES = 7'h10;
	localparam logic [6:0] DIV32_CYCLES = 7'h20;
	localparam logic [6:0] DIV64_CYCLES = 7'h40;
	// Bit periods of one conversion, of the post-abort wait, and the index of the result's top bit.
	localparam logic [3:0] CONV_PERIODS = 4'hB;
	localparam logic [1:0] ABORT_PERIODS = 2'h2;
	localparam logic [3:0] MSB_INDEX = 4'h9;
	// Sequencer states, one-hot.
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_SAMPLE = 4'b0010,
		ST_CONVERT = 4'b0100,
		ST_ABORT = 4'b1000
	} seq_state_t;
endpackage

// [rtl/conv_clock_divider.sv]
// Conversion bit-period tick generator: oscillator divider or internal RC clock edges.
`timescale 1ns/1ns
module conv_clock_divider
	import adc_seq_pkg::*;
(
	input wire logic i_clock,
	input wire logic i_reset,
	input wire logic i_clock_enable,
	input wire logic [2:0] i_conv_clock_select,
	input wire logic i_rc_level,
	output logic o_tick
);
	logic [6:0] count_r;
	logic [6:0] count_nxt;
	logic rc_prev_r;
	logic [6:0] period;
	logic rc_mode;
	logic div_tick;

	// Period lookup; the two unassigned codes give period zero and stop the clock.
	function automatic logic [6:0] div_period(input logic [2:0] sel);
		case (sel)
			SEL_DIV8: div_period = DIV8_CYCLES;
			SEL_DIV16: div_period = DIV16_CYCLES;
			SEL_DIV32: div_period = DIV32_CYCLES;
			SEL_DIV64: div_period = DIV64_CYCLES;
			default: div_period = 7'h00;
		endcase
	endfunction

	// Select the source and form the terminal count.
	assign rc_mode = (i_conv_clock_select[1:0] == SEL_RC_LOW);
	assign period = div_period(i_conv_clock_select);
	// A count left above a shorter new period ends at once instead of wrapping through the whole range.
	assign div_tick = (period != 7'h00) && (count_r >= period - 7'h01);
	assign count_nxt = (div_tick || rc_mode) ? 7'h00 : count_r + 7'h01;

	// Counter and RC edge tracker; the tick itself is registered so it is glitch free.
	always_ff @(posedge i_clock or posedge i_reset) begin
		if (i_reset) begin
			count_r <= 7'h00;
			rc_prev_r <= 1'b0;
			o_tick <= 1'b0;
		end else if (i_clock_enable) begin
			count_r <= count_nxt;
			rc_prev_r <= i_rc_level;
			o_tick <= rc_mode ? (i_rc_level && !rc_prev_r) : div_tick;
		end
	end
endmodule
